// *** inc/led_serial_pkg.sv ***
package led_serial_pkg;

  // ----------------------------------------------------------------------
  // Shift register and latch sizes
  // ----------------------------------------------------------------------
  localparam int MAIN_SR_W  = 288;
  localparam int AUX_SR_W   = 216;
  localparam int CFG_LAT_W  = 216;
  localparam int CFG_SPLIT  = 199;
  localparam int CHANNELS   = 24;
  localparam int PWM_CNT_W  = 12;
  localparam logic [11:0] PWM_LAST = 12'hfff;

  // ----------------------------------------------------------------------
  // Readback layout loaded into the common shift register
  // ----------------------------------------------------------------------
  localparam int RB_OPEN_LSB  = 0;
  localparam int RB_SHORT_LSB = 24;
  localparam int RB_OT_BIT    = 48;
  localparam int RB_CFG_LSB   = 49;

  // ----------------------------------------------------------------------
  // Synchronised pin bundle indices
  // ----------------------------------------------------------------------
  localparam int PIN_W     = 9;
  localparam int PIN_MCLK  = 0;
  localparam int PIN_MDAT  = 1;
  localparam int PIN_MLAT  = 2;
  localparam int PIN_ACLK  = 3;
  localparam int PIN_ADAT  = 4;
  localparam int PIN_BLANK = 5;
  localparam int PIN_PWM_R = 6;
  localparam int PIN_PWM_G = 7;
  localparam int PIN_PWM_B = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int AUX_IDLE_US   = 3000;
  localparam int AUX_IDLE_CYC  =
    (AUX_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0c;

  localparam int ST_GS_LOAD  = 0;
  localparam int ST_CFG_LOAD = 1;
  localparam int ST_AUX_LOAD = 2;
  localparam int ST_REPEAT   = 3;
  localparam int EVT_W       = 4;

  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  typedef struct packed {
    logic auto_repeat;
    logic timing_reset;
  } ctrl_t;

  typedef struct packed {
    logic [PWM_CNT_W-1:0] blue;
    logic [PWM_CNT_W-1:0] green;
    logic [PWM_CNT_W-1:0] red;
  } pwm_cnt_t;

endpackage

// *** logic/pin_sync_edge.sv ***
`timescale 1ns/10ps
module pin_sync_edge
  import led_serial_pkg::*;
#(
  parameter int W = PIN_W
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Pins and their sampled forms
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // The first stage is read only by the second stage.
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;

endmodule

// *** logic/led_serial_ports.sv ***
`timescale 1ns/10ps
// What this block does
// - Main serial input enters bit 0 of the 288-bit common register.
// - Each main shift clock rise shifts the common register toward MSB, except in a grayscale load cycle.
// - Main serial output shows the common register MSB.
// - Only the latch strobe rise moves common register data into a latch.
// - Strobe level at last main shift clock rise selects destination.
// - Selected low: all 288 bits go to the grayscale latch.
// - Selected high: bits 0-198 to config, 199-215 to aux register.
// - Flags and 199 config bits are shifted out on the main output.
// - Each aux shift clock rise shifts aux input into aux bit 0, except in a config load cycle.
// - Aux serial output shows the aux register MSB.
// - Aux register copies to config latch 3-7 ms after last aux clock.
// - Timing reset enabled: grayscale load makes an internal blank.
// - Auto repeat enabled: 4096th red count clock makes an internal blank.
// - Blank low forces outputs off and clears counters and timing.
// - Blank high: each count clock rise increments its group counter, except during an internal blank.
module led_serial_ports
  import led_serial_pkg::*;
#(
  parameter int AUX_IDLE_CYCLES = AUX_IDLE_CYC,
  parameter int IDLE_W          = 17
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  output logic                      irq,
  // Main serial port
  input  wire logic                 main_serial_in,
  input  wire logic                 main_shift_clock,
  input  wire logic                 main_latch_strobe,
  output logic                      main_serial_out,
  // Auxiliary serial port
  input  wire logic                 aux_serial_in,
  input  wire logic                 aux_shift_clock,
  output logic                      aux_serial_out,
  // Display timing
  input  wire logic                 blank_n,
  input  wire logic                 red_pwm_count_clock,
  input  wire logic                 green_pwm_count_clock,
  input  wire logic                 blue_pwm_count_clock,
  // Detector flags, on this clock
  input  wire logic [CHANNELS-1:0]  open_led_flag,
  input  wire logic [CHANNELS-1:0]  shorted_led_flag,
  input  wire logic                 overtemp_flag,
  // Latched data and display state
  output logic      [MAIN_SR_W-1:0] grayscale_latch,
  output logic      [CFG_LAT_W-1:0] config_latch,
  output pwm_cnt_t                  pwm_count,
  output logic                      internal_blank,
  output logic                      outputs_on
);

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_rise;

  pin_sync_edge #(
    .W (PIN_W)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in ({blue_pwm_count_clock, green_pwm_count_clock,
                red_pwm_count_clock, blank_n, aux_serial_in,
                aux_shift_clock, main_latch_strobe, main_serial_in,
                main_shift_clock}),
    .level    (pin_lvl),
    .rise     (pin_rise)
  );

  logic main_shift;
  logic strobe_rise;
  logic aux_shift;
  logic blank_lvl;
  assign main_shift  = pin_rise[PIN_MCLK];
  assign strobe_rise = pin_rise[PIN_MLAT];
  assign aux_shift   = pin_rise[PIN_ACLK];
  assign blank_lvl   = pin_lvl[PIN_BLANK];

  // ----------------------------------------------------------------------
  // Main port
  // ----------------------------------------------------------------------
  logic [MAIN_SR_W-1:0] main_sr_ff;
  logic [MAIN_SR_W-1:0] gs_latch_ff;
  logic                 dest_cfg_ff;
  logic                 gs_load;
  logic                 cfg_load;
  logic [MAIN_SR_W-1:0] readback;
  logic [CFG_LAT_W-1:0] config_latch_ff;

  // Strobe level is caught at every shift edge; the last one counts.
  always_ff @(posedge clock) begin
    if (reset) begin
      dest_cfg_ff <= 1'b0;
    end else if (main_shift) begin
      dest_cfg_ff <= pin_lvl[PIN_MLAT];
    end
  end

  assign gs_load  = strobe_rise && !dest_cfg_ff;
  assign cfg_load = strobe_rise && dest_cfg_ff;

  always_comb begin
    readback = '0;
    readback[RB_OPEN_LSB +: CHANNELS]  = open_led_flag;
    readback[RB_SHORT_LSB +: CHANNELS] = shorted_led_flag;
    readback[RB_OT_BIT]                = overtemp_flag;
    readback[RB_CFG_LSB +: CFG_SPLIT]  = config_latch_ff[CFG_SPLIT-1:0];
  end

  // A grayscale load refills the register with status for readback, so
  // the next frame shifted in pushes the flags out. A grayscale load wins
  // over a shift in the same cycle; a config strobe does not stop the shift.
  always_ff @(posedge clock) begin
    if (reset) begin
      main_sr_ff <= '0;
    end else if (gs_load) begin
      main_sr_ff <= readback;
    end else if (main_shift) begin
      main_sr_ff <= {main_sr_ff[MAIN_SR_W-2:0], pin_lvl[PIN_MDAT]};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      gs_latch_ff <= '0;
    end else if (gs_load) begin
      gs_latch_ff <= main_sr_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Auxiliary port
  // ----------------------------------------------------------------------
  logic [AUX_SR_W-1:0]  aux_sr_ff;
  logic [IDLE_W-1:0]    idle_cnt_ff;
  logic                 aux_pending_ff;
  logic                 aux_load;

  always_ff @(posedge clock) begin
    if (reset) begin
      aux_sr_ff <= '0;
    end else if (cfg_load) begin
      aux_sr_ff[AUX_SR_W-1:CFG_SPLIT] <=
        main_sr_ff[AUX_SR_W-1:CFG_SPLIT];
    end else if (aux_shift) begin
      aux_sr_ff <= {aux_sr_ff[AUX_SR_W-2:0], pin_lvl[PIN_ADAT]};
    end
  end

  // The idle timer restarts on every aux clock rise and fires once.
  always_ff @(posedge clock) begin
    if (reset) begin
      idle_cnt_ff    <= '0;
      aux_pending_ff <= 1'b0;
    end else if (aux_shift) begin
      idle_cnt_ff    <= '0;
      aux_pending_ff <= 1'b1;
    end else if (aux_load) begin
      aux_pending_ff <= 1'b0;
    end else if (aux_pending_ff) begin
      idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
  end

  assign aux_load = aux_pending_ff && !aux_shift &&
                    (idle_cnt_ff == IDLE_W'(AUX_IDLE_CYCLES - 1));

  // A strobe load wins; the host keeps clear of the aux timer window.
  always_ff @(posedge clock) begin
    if (reset) begin
      config_latch_ff <= '0;
    end else if (cfg_load) begin
      config_latch_ff[CFG_SPLIT-1:0] <= main_sr_ff[CFG_SPLIT-1:0];
    end else if (aux_load) begin
      config_latch_ff <= aux_sr_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Display timing
  // ----------------------------------------------------------------------
  ctrl_t    ctrl_ff;
  pwm_cnt_t cnt_ff;
  logic     int_blank_ff;
  logic     outputs_on_ff;
  logic     repeat_hit;
  logic     nxt_int_blank;

  assign repeat_hit = ctrl_ff.auto_repeat && blank_lvl &&
                      pin_rise[PIN_PWM_R] && (cnt_ff.red == PWM_LAST);
  assign nxt_int_blank = (ctrl_ff.timing_reset && gs_load) ||
                         repeat_hit;

  always_ff @(posedge clock) begin
    if (reset) begin
      int_blank_ff <= 1'b0;
    end else begin
      int_blank_ff <= nxt_int_blank;
    end
  end

  // Counters are cleared by either blank; only the red group drives the
  // repeat, since all groups are meant to run the same period.
  always_ff @(posedge clock) begin
    if (reset || !blank_lvl || int_blank_ff) begin
      cnt_ff <= '0;
    end else begin
      if (pin_rise[PIN_PWM_R]) begin
        cnt_ff.red <= cnt_ff.red + 1'b1;
      end
      if (pin_rise[PIN_PWM_G]) begin
        cnt_ff.green <= cnt_ff.green + 1'b1;
      end
      if (pin_rise[PIN_PWM_B]) begin
        cnt_ff.blue <= cnt_ff.blue + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      outputs_on_ff <= 1'b0;
    end else begin
      outputs_on_ff <= blank_lvl && !nxt_int_blank;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave and interrupt
  // ----------------------------------------------------------------------
  logic [EVT_W-1:0] status_ff;
  logic [EVT_W-1:0] mask_ff;
  logic [EVT_W-1:0] events;
  logic             pready_ff;
  logic [31:0]      prdata_ff;
  logic             pslverr_ff;
  logic             irq_ff;
  logic             access;
  logic             status_rd;

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS) ||
           (a == OFS_MASK) || (a == OFS_STATE);
  endfunction

  // No wait states: ready rises in the first access cycle.
  assign access    = psel && penable && pready_ff;
  assign status_rd = access && !pwrite && (paddr == OFS_STATUS);
  assign events    = {repeat_hit, aux_load, cfg_load, gs_load};

  always_ff @(posedge clock) begin
    if (reset) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !reg_hit(paddr);
      prdata_ff  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFS_CTRL:   prdata_ff <= {30'h0000_0000, ctrl_ff};
          OFS_STATUS: prdata_ff <= {28'h000_0000, status_ff};
          OFS_MASK:   prdata_ff <= {28'h000_0000, mask_ff};
          OFS_STATE:  prdata_ff <= {28'h000_0000, blank_lvl,
                                    int_blank_ff, aux_pending_ff,
                                    dest_cfg_ff};
          default:    prdata_ff <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
    end else if (access && pwrite) begin
      if (paddr == OFS_CTRL) begin
        ctrl_ff <= pwdata[1:0];
      end
      if (paddr == OFS_MASK) begin
        mask_ff <= pwdata[EVT_W-1:0];
      end
    end
  end

  // Only the bits that the read returned are cleared, so an event that
  // lands between the setup and the access cycle is not lost.
  always_ff @(posedge clock) begin
    if (reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_rd ? status_ff & ~prdata_ff[EVT_W-1:0]
                              : status_ff) | events;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pready          = pready_ff;
  assign prdata          = prdata_ff;
  assign pslverr         = pslverr_ff;
  assign irq             = irq_ff;
  assign main_serial_out = main_sr_ff[MAIN_SR_W-1];
  assign aux_serial_out  = aux_sr_ff[AUX_SR_W-1];
  assign grayscale_latch = gs_latch_ff;
  assign config_latch    = config_latch_ff;
  assign pwm_count       = cnt_ff;
  assign internal_blank  = int_blank_ff;
  assign outputs_on      = outputs_on_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_shift_main: assert property (main_shift && !gs_load |=>
    main_sr_ff[MAIN_SR_W-1:1] == $past(main_sr_ff[MAIN_SR_W-2:0]))
    else $error("common register did not shift");
  a_shift_lsb: assert property (main_shift && !gs_load |=>
    main_sr_ff[0] == $past(pin_lvl[PIN_MDAT]))
    else $error("main input not in bit 0");
  a_out_msb: assert property (main_shift && !gs_load |=>
    main_serial_out == $past(main_sr_ff[MAIN_SR_W-2]))
    else $error("main output not the MSB");
  a_gs_hold: assert property (!gs_load |=> $stable(gs_latch_ff))
    else $error("grayscale latch changed without strobe");
  a_gs_copy: assert property (gs_load |=>
    gs_latch_ff == $past(main_sr_ff))
    else $error("grayscale latch copy wrong");
  a_cfg_copy: assert property (cfg_load |=>
    config_latch_ff[CFG_SPLIT-1:0] == $past(main_sr_ff[CFG_SPLIT-1:0]) &&
    aux_sr_ff[AUX_SR_W-1:CFG_SPLIT] ==
    $past(main_sr_ff[AUX_SR_W-1:CFG_SPLIT]))
    else $error("config strobe copy wrong");
  a_dest_sel: assert property (main_shift ##1 (!main_shift)[*8]
    ##0 strobe_rise |-> cfg_load == $past(pin_lvl[PIN_MLAT], 8))
    else $error("destination not from last shift edge");
  a_readback: assert property (gs_load |=>
    main_sr_ff[RB_OT_BIT] == $past(overtemp_flag))
    else $error("overtemp flag not loaded for readback");
  a_aux_shift: assert property (aux_shift && !cfg_load |=>
    aux_sr_ff == {$past(aux_sr_ff[AUX_SR_W-2:0]), $past(pin_lvl[PIN_ADAT])})
    else $error("aux register did not shift");
  a_aux_copy: assert property (aux_load && !cfg_load |=>
    config_latch_ff == $past(aux_sr_ff))
    else $error("aux auto copy wrong");
  a_aux_early: assert property (aux_shift |=> !aux_load[*8])
    else $error("aux copy too soon after clock");
  a_dtr_blank: assert property (ctrl_ff.timing_reset && gs_load |=>
    int_blank_ff ##1 cnt_ff == '0)
    else $error("no blank on grayscale load");
  a_repeat: assert property (repeat_hit |=> int_blank_ff ##1
    cnt_ff.red == '0)
    else $error("no blank at end of period");
  a_blank_off: assert property (!blank_lvl |=>
    !outputs_on_ff && cnt_ff == '0)
    else $error("blank did not clear display");
  a_count_up: assert property (blank_lvl && !int_blank_ff &&
    pin_rise[PIN_PWM_G] |=> cnt_ff.green == $past(cnt_ff.green) + 1'b1)
    else $error("green counter did not advance");
  a_irq_level: assert property (|(status_ff & mask_ff) |=> irq_ff)
    else $error("interrupt missing");

  c_gs_load:   cover property (gs_load);
  c_cfg_load:  cover property (cfg_load);
  c_aux_load:  cover property (aux_load);
  c_repeat:    cover property (repeat_hit);

endmodule

// *** bench/host_serial_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Host display controller driving both serial ports
// ----------------------------------------------------------------------
module host_serial_model (
  // Clock
  input  wire logic clock,
  // Main port
  output logic      main_serial_in,
  output logic      main_shift_clock,
  output logic      main_latch_strobe,
  input  wire logic main_serial_out,
  // Auxiliary port
  output logic      aux_serial_in,
  output logic      aux_shift_clock
);
  localparam int HALF = 4;

  initial begin
    main_serial_in    = 1'b0;
    main_shift_clock  = 1'b0;
    main_latch_strobe = 1'b0;
    aux_serial_in     = 1'b0;
    aux_shift_clock   = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // The first bit sent ends at the far end of the register. The output
  // is sampled before each rise, so seen holds what was stored before.
  // A config frame raises the strobe before its first bit, so that it is
  // high at every rise; that early rise is itself a latch, selected by
  // the level at the previous frame's last rise.
  task automatic main_shift(input logic [287:0] d, input logic sel,
                            output logic [287:0] seen);
    @(posedge clock);
    main_latch_strobe <= sel;
    for (int k = 287; k >= 0; k--) begin
      main_serial_in    <= d[k];
      wait_cyc(HALF);
      seen[k] = main_serial_out;
      main_shift_clock  <= 1'b1;
      wait_cyc(HALF);
      main_shift_clock  <= 1'b0;
    end
    // The data pin has a pull-down, so it falls once released.
    main_serial_in    <= 1'b0;
    main_latch_strobe <= 1'b0;
  endtask

  task automatic main_latch;
    wait_cyc(HALF);
    main_latch_strobe <= 1'b1;
    wait_cyc(HALF);
    main_latch_strobe <= 1'b0;
    wait_cyc(HALF);
  endtask

  task automatic aux_shift(input logic [215:0] d);
    @(posedge clock);
    for (int k = 215; k >= 0; k--) begin
      aux_serial_in   <= d[k];
      wait_cyc(HALF);
      aux_shift_clock <= 1'b1;
      wait_cyc(HALF);
      aux_shift_clock <= 1'b0;
    end
    // No pull on this pin: show the opposite of the last bit once idle.
    aux_serial_in <= ~d[0];
  endtask
endmodule

// *** bench/led_serial_ports_test.sv ***
`timescale 1ns/10ps
module led_serial_ports_test;
  import led_serial_pkg::*;

  localparam int IDLE  = 50;
  localparam int LIMIT = 60000;
  localparam logic [287:0] GPAT  = {9{32'ha5c3_1e7f}};
  localparam logic [287:0] CPAT  = {9{32'h3c96_d20b}};
  localparam logic [215:0] APAT  = {27{8'h6b}};
  localparam logic [23:0]  OPEN  = 24'h5a_0f31;
  localparam logic [23:0]  SHORT = 24'hc3_1e82;

  logic           clock;
  logic           reset;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic           pready;
  logic [31:0]    prdata;
  logic           pslverr;
  logic           irq;
  logic           msi;
  logic           msc;
  logic           mls;
  logic           mso;
  logic           asi;
  logic           asc;
  logic           aso;
  logic           blank_n;
  logic [2:0]     pc;
  logic [287:0]   gray;
  logic [215:0]   cfg;
  pwm_cnt_t       cnt;
  logic           iblank;
  logic           outputs_on;
  logic           ot;
  logic [287:0]   seen;
  logic [31:0]    rd;
  logic           err;
  int             err_count = 0;
  int             n_compared = 0;
  int             nblank = 0;
  int             nb;
  int             cyc = 0;

  led_serial_ports #(.AUX_IDLE_CYCLES(IDLE), .IDLE_W(17)) led_serial_ports_i (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .main_serial_in(msi), .main_shift_clock(msc),
    .main_latch_strobe(mls), .main_serial_out(mso),
    .aux_serial_in(asi), .aux_shift_clock(asc), .aux_serial_out(aso),
    .blank_n(blank_n), .red_pwm_count_clock(pc[0]),
    .green_pwm_count_clock(pc[1]), .blue_pwm_count_clock(pc[2]),
    .open_led_flag(OPEN), .shorted_led_flag(SHORT), .overtemp_flag(ot),
    .grayscale_latch(gray), .config_latch(cfg), .pwm_count(cnt),
    .internal_blank(iblank), .outputs_on(outputs_on));

  host_serial_model host_serial_model_i (
    .clock(clock), .main_serial_in(msi), .main_shift_clock(msc),
    .main_latch_strobe(mls), .main_serial_out(mso),
    .aux_serial_in(asi), .aux_shift_clock(asc));

  // ----------------------------------------------------------------------
  // Clock, blank pulse count and hang guard
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (iblank === 1'b1) nblank++;
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Checks and bus access
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [287:0] e,
                     input logic [287:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("register read", e, rd);
  endtask

  task automatic pulse(input logic [2:0] which, input int n);
    repeat (n) begin
      @(posedge clock);
      pc <= which;
      repeat (4) @(posedge clock);
      pc <= 3'b000;
      repeat (3) @(posedge clock);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    blank_n = 1'b0;
    pc      = 3'b000;
    ot      = 1'b0;
    repeat (12) @(posedge clock);
    reset   <= 1'b0;
    blank_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(OFS_CTRL, 32'h0000_0000);
    rd_chk(OFS_MASK, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped error", 1, err);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    rd_chk(OFS_CTRL, 32'h0000_0001);
    // Automatic copy must wait for the idle time, then take all bits.
    host_serial_model_i.aux_shift(APAT);
    repeat (40) @(posedge clock);
    chk("early aux copy", 0, cfg);
    repeat (70) @(posedge clock);
    chk("aux copy", APAT, cfg);
    chk("aux out", APAT[215], aso);
    chk("masked irq", 0, irq);
    rd_chk(OFS_STATUS, 32'h0000_0004);
    apb(1'b1, OFS_MASK, 32'h0000_000f);
    repeat (130) @(posedge clock);
    // The early strobe rise of the config frame latches the still empty
    // register as grayscale, since no shift has yet seen the strobe high.
    host_serial_model_i.main_shift(CPAT, 1'b1, seen);
    chk("gs before strobe", 0, gray);
    chk("cfg before strobe", APAT, cfg);
    host_serial_model_i.main_latch();
    repeat (4) @(posedge clock);
    chk("cfg write", {APAT[215:199], CPAT[198:0]}, cfg);
    chk("aux top bit", CPAT[215], aso);
    chk("gs kept", 0, gray);
    chk("irq raised", 1, irq);
    rd_chk(OFS_STATUS, 32'h0000_0003);
    rd_chk(OFS_STATE, 32'h0000_0009);
    repeat (3) @(posedge clock);
    chk("irq cleared", 0, irq);
    nb = nblank;
    ot <= 1'b1;
    host_serial_model_i.main_shift(GPAT, 1'b0, seen);
    chk("chained out", CPAT, seen);
    host_serial_model_i.main_latch();
    repeat (4) @(posedge clock);
    chk("gs write", GPAT, gray);
    chk("timing reset blank", nb + 1, nblank);
    rd_chk(OFS_STATUS, 32'h0000_0001);
    host_serial_model_i.main_shift('0, 1'b0, seen);
    chk("readback", {40'h0, CPAT[198:0], 1'b1, SHORT, OPEN}, seen);
    // Display counters: count first, so that blank has something to clear.
    pulse(3'b111, 1);
    pulse(3'b101, 1);
    pulse(3'b001, 1);
    chk("group counts", {12'h002, 12'h001, 12'h003}, cnt);
    blank_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk("blank counts", 0, cnt);
    chk("blank outputs", 0, outputs_on);
    pulse(3'b001, 1);
    chk("blank holds", 0, cnt);
    blank_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk("outputs on", 1, outputs_on);
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    pulse(3'b001, 4095);
    chk("red full", {12'h000, 12'h000, 12'hfff}, cnt);
    nb = nblank;
    pulse(3'b001, 1);
    chk("repeat blank", nb + 1, nblank);
    chk("repeat restart", 0, cnt);
    rd_chk(OFS_STATUS, 32'h0000_0008);
    give_verdict();
  end
endmodule
